/* File: verilog/aci_map.svh */
// Operation
// RULE_01: data memory row address comes from instruction bits 9..8.
// RULE_02: data memory column address comes from instruction bits 7..4.
// RULE_03: bits 3..0 are immediate for memory forms, register for others.
// RULE_04: register field selects one of sixteen general registers.
// RULE_05: group 0100 adds memory into register, carry and skip per variant.
// RULE_06: group 0101 adds immediate into memory, carry and skip per variant.
// RULE_07: group 0110 subtracts memory from register, borrow per variant.
// RULE_08: group 0111 subtracts immediate from memory, borrow per variant.
// RULE_09: skip variants skip on carry out or on borrow out.
// RULE_10: 000100 skips when register equals memory, nothing stored.
// RULE_11: 000101 skips when memory equals immediate, memory unchanged.
// RULE_12: 000001 skips when memory differs from immediate.
// RULE_13: 000011 skips when register minus memory gives no borrow.
// RULE_14: 000111 skips when memory minus immediate gives no borrow.
// RULE_15: less-than compare skips when memory below immediate; own opcode.
// RULE_16: every add or subtract here updates the carry/borrow flag; the code updates it for groups 0100-0111 only, compares leave it.
// RULE_17: after a skip the next instruction is squashed as a no-op.
`ifndef ACI_MAP_SVH
`define ACI_MAP_SVH

// bits 15..12 of the arithmetic groups
`define ACI_GRP_ADD_REG 4'h4
`define ACI_GRP_ADD_IMM 4'h5
`define ACI_GRP_SUB_REG 4'h6
`define ACI_GRP_SUB_IMM 4'h7

// bits 15..10 of the compare group
`define ACI_CMP_EQ_REG 6'h04
`define ACI_CMP_EQ_IMM 6'h05
`define ACI_CMP_NE_IMM 6'h01
`define ACI_CMP_GE_REG 6'h03
`define ACI_CMP_GE_IMM 6'h07
// printed code clashes with ge_reg; moved to a free slot
`define ACI_CMP_LT_IMM 6'h02

// positions inside bits 11..10
`define ACI_VAR_SKIP_BIT 0
`define ACI_VAR_CIN_BIT  1

`define ACI_CARRY_RST 1'b0

`endif

/* File: verilog/aci_pkg.sv */
package aci_pkg;

  typedef struct packed {
    logic [3:0] grp;
    logic [1:0] vsel;
    logic [1:0] row;
    logic [3:0] col;
    logic [3:0] low;
  } aci_instr_t;

  typedef struct packed {
    logic [1:0] row;
    logic [3:0] col;
    logic [3:0] regsel;
  } aci_addr_t;

  typedef struct packed {
    logic       reg_we;
    logic       mem_we;
    aci_addr_t  addr;
    logic [3:0] data;
  } aci_wr_t;

  typedef enum logic [2:0] {
    ACI_NONE,
    ACI_ADD,
    ACI_SUB,
    ACI_EQ,
    ACI_NE,
    ACI_GE,
    ACI_LT
  } aci_op_t;

endpackage

/* File: verilog/aci_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aci_map.svh"

module aci_decode
(
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  // instruction from fetch
  input  wire logic                instr_valid,
  input  wire aci_pkg::aci_instr_t instr,
  // operands read at rd_addr
  input  wire logic [3:0]          mem_rdata,
  input  wire logic [3:0]          reg_rdata,
  // operand read request
  output logic                     rd_req_ff,
  output aci_pkg::aci_addr_t       rd_addr_ff,
  // result and sequencing
  output aci_pkg::aci_wr_t         wr_ff,
  output logic                     skip_ff,
  output logic                     squash_ff,
  output logic                     carry_ff
);
  import aci_pkg::*;

  logic       rst_s1_ff;
  logic       rst_q_ff;
  logic       s1_vld_ff;
  logic       nxt_s1_vld;
  aci_instr_t s1_ins_ff;
  aci_instr_t nxt_s1_ins;
  logic       skip_pend_ff;
  logic       nxt_skip_pend;
  logic       nxt_rd_req;
  aci_addr_t  nxt_rd_addr;
  aci_wr_t    nxt_wr;
  logic       nxt_skip;
  logic       nxt_squash;
  logic       nxt_carry;
  aci_op_t    op;
  logic       imm_form;
  logic       cin_en;
  logic       skp_en;
  logic [3:0] a_opd;
  logic [3:0] b_opd;
  logic       cin;
  logic [4:0] sum5;
  logic [4:0] dif5;
  logic       ex_go;
  logic       take;
  logic       arith;

  // reset released through two flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_ff <= 1'b0;
      rst_q_ff  <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_q_ff  <= rst_s1_ff;
    end
  end

  always_comb
  begin
    op       = ACI_NONE;
    imm_form = 1'b0;
    cin_en   = s1_ins_ff.vsel[`ACI_VAR_CIN_BIT];
    skp_en   = s1_ins_ff.vsel[`ACI_VAR_SKIP_BIT];
    unique case (s1_ins_ff.grp)
      `ACI_GRP_ADD_REG: op = ACI_ADD; // see RULE_05
      `ACI_GRP_ADD_IMM:
      begin
        op       = ACI_ADD; // see RULE_06
        imm_form = 1'b1;
      end
      `ACI_GRP_SUB_REG: op = ACI_SUB; // see RULE_07
      `ACI_GRP_SUB_IMM:
      begin
        op       = ACI_SUB; // see RULE_08
        imm_form = 1'b1;
      end
      default:
      begin
        cin_en = 1'b0;
        skp_en = 1'b0;
        unique case ({s1_ins_ff.grp, s1_ins_ff.vsel})
          `ACI_CMP_EQ_REG: op = ACI_EQ; // see RULE_10
          `ACI_CMP_EQ_IMM:
          begin
            op       = ACI_EQ; // see RULE_11
            imm_form = 1'b1;
          end
          `ACI_CMP_NE_IMM:
          begin
            op       = ACI_NE; // see RULE_12
            imm_form = 1'b1;
          end
          `ACI_CMP_GE_REG: op = ACI_GE; // see RULE_13
          `ACI_CMP_GE_IMM:
          begin
            op       = ACI_GE; // see RULE_14
            imm_form = 1'b1;
          end
          `ACI_CMP_LT_IMM:
          begin
            op       = ACI_LT; // see RULE_15
            imm_form = 1'b1;
          end
          default: op = ACI_NONE;
        endcase
      end
    endcase

    // memory forms: M op I; register forms: r op M
    a_opd = imm_form ? mem_rdata : reg_rdata; // see RULE_03
    b_opd = imm_form ? s1_ins_ff.low : mem_rdata; // see RULE_03
    cin   = cin_en & carry_ff;
    sum5  = {1'b0, a_opd} + {1'b0, b_opd} + {4'h0, cin};
    dif5  = {1'b0, a_opd} - {1'b0, b_opd} - {4'h0, cin};
    arith = (op == ACI_ADD) || (op == ACI_SUB);
    ex_go = s1_vld_ff & ~skip_pend_ff; // see RULE_17

    take = 1'b0;
    unique case (op)
      ACI_ADD: take = skp_en & sum5[4]; // see RULE_09
      ACI_SUB: take = skp_en & dif5[4]; // see RULE_09
      ACI_EQ:  take = (dif5[3:0] == 4'h0);
      ACI_NE:  take = (dif5[3:0] != 4'h0);
      ACI_GE:  take = ~dif5[4];
      ACI_LT:  take = dif5[4];
      ACI_NONE: take = 1'b0;
    endcase

    // stage 1: capture and request operands
    nxt_s1_vld = instr_valid;
    nxt_s1_ins = instr_valid ? instr : s1_ins_ff;
    nxt_rd_req = instr_valid;
    nxt_rd_addr = rd_addr_ff;
    if (instr_valid)
    begin
      nxt_rd_addr.row    = instr.row; // see RULE_01
      nxt_rd_addr.col    = instr.col; // see RULE_02
      nxt_rd_addr.regsel = instr.low; // see RULE_04
    end

    // stage 2: execute; foreign opcodes still consume a pending skip
    nxt_skip_pend = s1_vld_ff ? (ex_go & take) : skip_pend_ff; // see RULE_17
    nxt_skip      = ex_go & take;
    nxt_squash    = s1_vld_ff & skip_pend_ff; // see RULE_17
    nxt_wr.reg_we = ex_go & arith & ~imm_form; // see RULE_05
    nxt_wr.mem_we = ex_go & arith & imm_form; // see RULE_06
    nxt_wr.addr   = '{row: s1_ins_ff.row, col: s1_ins_ff.col,
                      regsel: s1_ins_ff.low};
    nxt_wr.data   = (op == ACI_ADD) ? sum5[3:0] : dif5[3:0];
    nxt_carry     = carry_ff;
    if (ex_go & arith)
      nxt_carry = (op == ACI_ADD) ? sum5[4] : dif5[4]; // see RULE_16
  end

  // clk_en low freezes every flop except the two reset synchronizer flops
  always_ff @(posedge sys_clk or negedge rst_q_ff)
  begin
    if (!rst_q_ff)
    begin
      s1_vld_ff    <= 1'b0;
      s1_ins_ff    <= '0;
      skip_pend_ff <= 1'b0;
      rd_req_ff    <= 1'b0;
      rd_addr_ff   <= '0;
      wr_ff        <= '0;
      skip_ff      <= 1'b0;
      squash_ff    <= 1'b0;
      carry_ff     <= `ACI_CARRY_RST;
    end
    else if (clk_en)
    begin
      s1_vld_ff    <= nxt_s1_vld;
      s1_ins_ff    <= nxt_s1_ins;
      skip_pend_ff <= nxt_skip_pend;
      rd_req_ff    <= nxt_rd_req;
      rd_addr_ff   <= nxt_rd_addr;
      wr_ff        <= nxt_wr;
      skip_ff      <= nxt_skip;
      squash_ff    <= nxt_squash;
      carry_ff     <= nxt_carry;
    end
  end

  default clocking cb @(posedge sys_clk iff clk_en);
  endclocking
  default disable iff (!rst_q_ff);

  a_row_field: assert property ( // see RULE_01
    instr_valid |=> rd_addr_ff.row == $past(instr.row))
    else $error("row address not taken from bits 9..8");
  a_col_field: assert property ( // see RULE_02
    instr_valid |=> rd_addr_ff.col == $past(instr.col))
    else $error("column address not taken from bits 7..4");
  a_reg_select: assert property ( // see RULE_04
    instr_valid |=> rd_req_ff && rd_addr_ff.regsel == $past(instr.low))
    else $error("register select wrong");
  a_add_reg_wr: assert property ( // see RULE_05
    ex_go && s1_ins_ff.grp == `ACI_GRP_ADD_REG && !cin_en
    |=> wr_ff.reg_we && !wr_ff.mem_we
        && wr_ff.data == 4'($past(reg_rdata) + $past(mem_rdata)))
    else $error("register add result wrong");
  a_add_imm_wr: assert property ( // see RULE_06
    ex_go && s1_ins_ff.grp == `ACI_GRP_ADD_IMM && !cin_en
    |=> wr_ff.mem_we
        && wr_ff.data == 4'($past(mem_rdata) + $past(s1_ins_ff.low)))
    else $error("memory immediate add result wrong");
  a_sub_reg_wr: assert property ( // see RULE_07
    ex_go && s1_ins_ff.grp == `ACI_GRP_SUB_REG && !cin_en
    |=> wr_ff.reg_we
        && wr_ff.data == 4'($past(reg_rdata) - $past(mem_rdata)))
    else $error("register subtract result wrong");
  a_skip_equal: assert property ( // see RULE_10
    ex_go && op == ACI_EQ && !imm_form && reg_rdata == mem_rdata
    |=> skip_ff && !wr_ff.reg_we)
    else $error("equal compare did not skip");
  a_carry_update: assert property ( // see RULE_16
    ex_go && op == ACI_ADD |=> carry_ff == $past(sum5[4]))
    else $error("carry flag not updated");
  // pending skip may wait several cycles for the next instruction
  a_squash_next: assert property ( // see RULE_17
    s1_vld_ff && skip_pend_ff
    |=> squash_ff && !wr_ff.reg_we && !wr_ff.mem_we && !skip_ff)
    else $error("instruction after skip not squashed");

  c_skip_taken: cover property (skip_ff);
  c_squashed: cover property (squash_ff);
  c_carry_chain: cover property (ex_go && cin);
endmodule

`default_nettype wire

/* File: dv/aci_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module aci_far_model
(
  // clock
  input  wire logic               sys_clk,
  // operand reads
  input  wire logic               rd_req,
  input  wire aci_pkg::aci_addr_t rd_addr,
  output logic [3:0]              mem_rdata,
  output logic [3:0]              reg_rdata,
  // result writes
  input  wire aci_pkg::aci_wr_t   wr
);
  import aci_pkg::*;
  logic [3:0] mem [64];
  logic [3:0] gpr [16];
  logic [3:0] m_v;
  logic [3:0] r_v;
  initial
  begin
    for (int i = 0; i < 64; i++) mem[i] = 4'(i * 7 + 3);
    for (int i = 0; i < 16; i++) gpr[i] = 4'(i * 5 + 1);
  end
  assign m_v = mem[{rd_addr.row, rd_addr.col}];
  assign r_v = gpr[rd_addr.regsel];
  // outside a read, junk instead of stale data
  assign mem_rdata = rd_req ? m_v : ~m_v;
  assign reg_rdata = rd_req ? r_v : ~r_v;
  always @(posedge sys_clk)
  begin
    if (wr.mem_we) mem[{wr.addr.row, wr.addr.col}] <= wr.data;
    if (wr.reg_we) gpr[wr.addr.regsel] <= wr.data;
  end
endmodule
`default_nettype wire

/* File: dv/test_arith_compare_instr_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module test_arith_compare_instr_decode;
  import aci_pkg::*;
  logic sys_clk, rst_n, clk_en, instr_valid, rd_req_ff;
  logic skip_ff, squash_ff, carry_ff, c, pend;
  logic res_due = 1'b0;
  logic [3:0] mem_rdata, reg_rdata;
  logic [3:0] mem [64];
  logic [3:0] gpr [16];
  logic [31:0] seed;
  logic [18:0] e;
  logic [18:0] expq [$];
  aci_instr_t instr, ins;
  aci_addr_t rd_addr_ff;
  aci_wr_t wr_ff;
  int errors, total_checks, gap;
  aci_decode u_aci_decode (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(clk_en), .instr_valid(instr_valid), .instr(instr),
    .mem_rdata(mem_rdata), .reg_rdata(reg_rdata),
    .rd_req_ff(rd_req_ff), .rd_addr_ff(rd_addr_ff), .wr_ff(wr_ff),
    .skip_ff(skip_ff), .squash_ff(squash_ff), .carry_ff(carry_ff));
  aci_far_model u_aci_far_model (.sys_clk(sys_clk), .rd_req(rd_req_ff),
    .rd_addr(rd_addr_ff), .mem_rdata(mem_rdata),
    .reg_rdata(reg_rdata), .wr(wr_ff));
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // expected result from operands held in the mirror
  task automatic issue(input aci_instr_t i);
    logic [3:0] m, r, lo;
    logic [4:0] s;
    logic [4:0] ci;
    logic sk, rw, mw, nc;
    lo = i.low;
    m = mem[{i.row, i.col}];
    r = gpr[lo];
    ci = 5'(i.vsel[1] & c);
    {sk, rw, mw, nc, s} = {3'h0, c, 5'h00};
    case (i.grp)
      4'h4: {rw, s} = {1'b1, 5'(r) + 5'(m) + ci};
      4'h5: {mw, s} = {1'b1, 5'(m) + 5'(lo) + ci};
      4'h6: {rw, s} = {1'b1, 5'(r) - 5'(m) - ci};
      4'h7: {mw, s} = {1'b1, 5'(m) - 5'(lo) - ci};
      default:
        case ({i.grp, i.vsel})
          6'h04: sk = (r == m);
          6'h05: sk = (m == lo);
          6'h01: sk = (m != lo);
          6'h03: sk = (r >= m);
          6'h07: sk = (m >= lo);
          6'h02: sk = (m < lo);
          default: sk = 1'b0;
        endcase
    endcase
    if (rw | mw) {nc, sk} = {s[4], i.vsel[0] & s[4]};
    if (pend) {rw, mw, sk, nc} = {3'h0, c};
    if (!(rw | mw)) s = 5'h00;
    expq.push_back({rw, mw, i.row, i.col, lo, s[3:0], sk, pend, nc});
    if (rw) gpr[lo] = s[3:0];
    if (mw) mem[{i.row, i.col}] = s[3:0];
    {c, pend} = {nc, sk};
  endtask
  always @(posedge sys_clk)
  begin
    if (clk_en && res_due)
    begin
      if (expq.size() == 0)
        check("stray result", 1, 0);
      else
      begin
        e = expq.pop_front();
        check("we", {wr_ff.reg_we, wr_ff.mem_we}, e[18:17]);
        if (e[18] | e[17]) check("addr", wr_ff.addr, e[16:7]);
        if (e[18] | e[17]) check("data", wr_ff.data, e[6:3]);
        check("skip", skip_ff, e[2]);
        check("squash", squash_ff, e[1]);
        check("carry", carry_ff, e[0]);
      end
    end
    if (clk_en) res_due <= rd_req_ff;
  end
  initial
  begin
    {rst_n, clk_en, instr_valid, c, pend} = 5'h00;
    {instr, seed, errors, total_checks, gap} = {16'h0000, 32'h13, 96'h0};
    for (int i = 0; i < 64; i++) mem[i] = 4'(i * 7 + 3);
    for (int i = 0; i < 16; i++) gpr[i] = 4'(i * 5 + 1);
    repeat (8) @(posedge sys_clk);
    check("reset", {rd_req_ff, wr_ff, skip_ff, squash_ff, carry_ff}, 0);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // one enabled idle cycle lets each write land before the next read
    for (int n = 0; n < 3000; n++)
    begin
      @(posedge sys_clk);
      seed = xs(seed);
      clk_en <= (seed[1:0] != 2'h0);
      if (seed[1:0] != 2'h0 && gap == 0)
      begin
        ins = seed[31:16];
        if (seed[4]) ins.grp[3] = 1'b0;
        instr <= ins;
        instr_valid <= 1'b1;
        issue(ins);
        gap = 1;
      end
      else
      begin
        instr_valid <= 1'b0;
        if (seed[1:0] != 2'h0 && gap > 0) gap--;
      end
    end
    // let the last word be taken before dropping valid
    @(posedge sys_clk);
    clk_en <= 1'b1;
    instr_valid <= 1'b0;
    for (int k = 0; k < 20 && expq.size() != 0; k++) @(posedge sys_clk);
    if (expq.size() != 0) check("drain", expq.size(), 0);
    give_verdict();
  end
endmodule
`default_nettype wire
